// [rtl/uoir_regs.sv]
// interface control, otg control and rising-event enable registers
// assumes the ulpi front end decodes register commands on clk and
// presents one-cycle write and read strobes with an immediate address
`include "uoir_defines.svh"
`default_nettype none

module uoir_regs
#(
  parameter int ID_SETTLE_CYCLES = `UOIR_ID_SETTLE_CYC
)
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire uoir_pkg::uoir_addr_t reg_addr,
  input  wire uoir_pkg::uoir_byte_t reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output uoir_pkg::uoir_byte_t reg_rdata,
  output logic                reg_rvalid,
  input  wire logic           low_power_n,
  input  wire logic           uart_exit,
  input  wire logic           serial_exit,
  input  wire logic           ext_vbus_ind_in,
  input  wire logic           int_vbus_cmp,
  input  wire logic           id_grounded,
  input  wire logic           session_end,
  input  wire logic           session_ok,
  input  wire logic           host_disc,
  output logic                protect_en,
  output logic                rx_vbus_valid,
  output logic                auto_wake_signal,
  output logic                serial_clk_on,
  output logic                uart_mode_sel,
  output logic                serial3_mode_sel,
  output logic                serial6_mode_sel,
  output logic                pump_enable_out,
  output logic                vbus_drive,
  output logic                vbus_charge,
  output logic                vbus_discharge,
  output logic                dminus_pd_en,
  output logic                dplus_pd_en,
  output logic                id_pu_en,
  output logic [4:0]          rise_event,
  output logic                rise_any
);
  import uoir_pkg::*;

  localparam int CW = $clog2(ID_SETTLE_CYCLES + 1);

  // refuse settle counts the counter cannot serve
  initial
  begin
    if (ID_SETTLE_CYCLES < 1)
      $error("ID_SETTLE_CYCLES must be at least 1");
  end

  uoir_byte_t ifc_reg;
  uoir_byte_t ifc_next;
  uoir_byte_t otg_reg;
  uoir_byte_t otg_next;
  uoir_byte_t rise_reg;
  uoir_byte_t rise_next;
  uoir_op_e   ifc_op;
  uoir_op_e   otg_op;
  uoir_op_e   rise_op;

  // base write replaces, set ors, clear masks off; unmasked bits hold
  function automatic uoir_byte_t wr_apply(
    input uoir_byte_t cur,
    input uoir_byte_t d,
    input uoir_op_e   op,
    input uoir_byte_t wmask
  );
    uoir_byte_t v;
    case (op)
      UOIR_OP_BASE: v = d;
      UOIR_OP_SET:  v = cur | d;
      UOIR_OP_CLR:  v = cur & ~d;
      default:      v = cur;
    endcase
    return (v & wmask) | (cur & ~wmask);
  endfunction

  // address decode into per-register write operations
  always_comb
  begin
    ifc_op  = UOIR_OP_NONE;
    otg_op  = UOIR_OP_NONE;
    rise_op = UOIR_OP_NONE;
    if (reg_wr)
    begin
      case (reg_addr)
        `UOIR_A_IFC:      ifc_op  = UOIR_OP_BASE;
        `UOIR_A_IFC_SET:  ifc_op  = UOIR_OP_SET;
        `UOIR_A_IFC_CLR:  ifc_op  = UOIR_OP_CLR;
        `UOIR_A_OTG:      otg_op  = UOIR_OP_BASE;
        `UOIR_A_OTG_SET:  otg_op  = UOIR_OP_SET;
        `UOIR_A_OTG_CLR:  otg_op  = UOIR_OP_CLR;
        `UOIR_A_RISE:     rise_op = UOIR_OP_BASE;
        `UOIR_A_RISE_SET: rise_op = UOIR_OP_SET;
        default:          ;
      endcase
    end
  end

  // interface control: mode exits clear first, a write then overrides
  // so a link write in the exit cycle is never lost
  always_comb
  begin
    ifc_next = ifc_reg;
    if (uart_exit)
      ifc_next[`UOIR_IFC_UART] = 1'b0;
    if (serial_exit)
    begin
      ifc_next[`UOIR_IFC_SER3] = 1'b0;
      ifc_next[`UOIR_IFC_SER6] = 1'b0;
    end
    // the 6-pin bit is only reachable through the base address
    ifc_next = wr_apply(ifc_next, reg_wdata, ifc_op,
      (ifc_op == UOIR_OP_BASE) ? `UOIR_IFC_WMASK
                               : `UOIR_IFC_AMASK);
  end

  always_comb
  begin
    otg_next  = wr_apply(otg_reg, reg_wdata, otg_op, `UOIR_OTG_WMASK);
    rise_next = wr_apply(rise_reg, reg_wdata, rise_op,
                         `UOIR_RISE_WMASK);
  end

  // register state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ifc_reg  <= `UOIR_IFC_RST;
      otg_reg  <= `UOIR_OTG_RST;
      rise_reg <= `UOIR_RISE_RST;
    end
    else
    begin
      ifc_reg  <= ifc_next;
      otg_reg  <= otg_next;
      rise_reg <= rise_next;
    end
  end

  // read data: aliases return their base register, others read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `UOIR_A_IFC, `UOIR_A_IFC_SET, `UOIR_A_IFC_CLR:
            reg_rdata <= ifc_reg;
          `UOIR_A_OTG, `UOIR_A_OTG_SET, `UOIR_A_OTG_CLR:
            reg_rdata <= otg_reg;
          `UOIR_A_RISE, `UOIR_A_RISE_SET:
            reg_rdata <= rise_reg & `UOIR_RISE_WMASK;
          default:
            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // analog and pin levels: three stages, a change counts once the
  // last two agree, so a single metastable sample cannot leak through
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] sync3_reg;
  logic [5:0] lvl_reg;
  logic [5:0] raw_in;

  assign raw_in = {ext_vbus_ind_in, id_grounded, session_end,
                   session_ok, int_vbus_cmp, host_disc};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      sync3_reg <= 6'h00;
      lvl_reg   <= 6'h00;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 6; i++)
        if (sync2_reg[i] == sync3_reg[i])
          lvl_reg[i] <= sync3_reg[i];
    end
  end

  logic ind_lvl;
  logic cmp_lvl;
  logic ind_c;
  logic ind_q;
  logic vbus_sel;

  assign ind_lvl = lvl_reg[5];
  assign cmp_lvl = lvl_reg[1];
  // complement stage, then optional comparator qualification
  assign ind_c = ifc_reg[`UOIR_IFC_INVERT] ? ~ind_lvl : ind_lvl;
  assign ind_q = ifc_reg[`UOIR_IFC_UNQUAL] ? ind_c
                                           : (ind_c & cmp_lvl);
  assign vbus_sel = otg_reg[`UOIR_OTG_EXTSRC] ? ind_q : cmp_lvl;

  // id settle timer: restarts while the pullup is off
  logic [CW-1:0] id_cnt_reg;
  logic          id_ok;

  assign id_ok = otg_reg[`UOIR_OTG_ID_PU] &&
                 (id_cnt_reg == CW'(ID_SETTLE_CYCLES));

  always_ff @(posedge clk)
  begin
    if (rst)
      id_cnt_reg <= '0;
    else if (!otg_reg[`UOIR_OTG_ID_PU])
      id_cnt_reg <= '0;
    else if (!id_ok)
      id_cnt_reg <= id_cnt_reg + CW'(1);
  end

  // rising-edge detection on the event sources
  logic [4:0] src;
  logic [4:0] src_prev_reg;
  logic [4:0] gate;
  logic       host_mode;

  assign host_mode = otg_reg[`UOIR_OTG_DM_PD] &
                     otg_reg[`UOIR_OTG_DP_PD];
  assign src[`UOIR_EV_ID]    = lvl_reg[4];
  assign src[`UOIR_EV_SEND]  = lvl_reg[3];
  assign src[`UOIR_EV_SOK]   = lvl_reg[2];
  assign src[`UOIR_EV_VBUS]  = vbus_sel;
  assign src[`UOIR_EV_HDISC] = lvl_reg[0];

  // per-source qualifiers beside the enable bits
  always_comb
  begin
    gate = rise_reg[4:0];
    gate[`UOIR_EV_ID]    = gate[`UOIR_EV_ID] & id_ok;
    gate[`UOIR_EV_HDISC] = gate[`UOIR_EV_HDISC] & host_mode;
  end

  // the id history tracks the level while it is masked, so a rise
  // seen during the settle window cannot fire once sampling settles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      src_prev_reg <= 5'h00;
      rise_event   <= 5'h00;
      rise_any     <= 1'b0;
    end
    else
    begin
      src_prev_reg <= src;
      rise_event <= src & ~src_prev_reg & gate;
      rise_any   <= |(src & ~src_prev_reg & gate);
    end
  end

  // control outputs, registered from the next register values; rx_vbus_valid from vbus_sel
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      protect_en       <= 1'b1;
      auto_wake_signal <= 1'b1;
      uart_mode_sel    <= 1'b0;
      serial3_mode_sel <= 1'b0;
      serial6_mode_sel <= 1'b0;
      pump_enable_out  <= 1'b0;
      vbus_drive       <= 1'b0;
      vbus_charge      <= 1'b0;
      vbus_discharge   <= 1'b0;
      dminus_pd_en     <= 1'b1;
      dplus_pd_en      <= 1'b1;
      id_pu_en         <= 1'b0;
      rx_vbus_valid    <= 1'b0;
    end
    else
    begin
      protect_en       <= ~ifc_next[`UOIR_IFC_PROT_DIS];
      auto_wake_signal <= ifc_next[`UOIR_IFC_AUTOWAKE];
      uart_mode_sel    <= ifc_next[`UOIR_IFC_UART];
      serial3_mode_sel <= ifc_next[`UOIR_IFC_SER3];
      serial6_mode_sel <= ifc_next[`UOIR_IFC_SER6];
      pump_enable_out  <= otg_next[`UOIR_OTG_EXTSUP] &
                          otg_next[`UOIR_OTG_DRIVE];
      vbus_drive       <= otg_next[`UOIR_OTG_DRIVE];
      // charge and discharge follow the link; it owns their sequencing
      vbus_charge      <= otg_next[`UOIR_OTG_CHARGE];
      vbus_discharge   <= otg_next[`UOIR_OTG_DISCH];
      dminus_pd_en     <= otg_next[`UOIR_OTG_DM_PD];
      dplus_pd_en      <= otg_next[`UOIR_OTG_DP_PD];
      id_pu_en         <= otg_next[`UOIR_OTG_ID_PU];
      rx_vbus_valid    <= vbus_sel;
    end
  end

  // clock power: only a non-suspended alternate mode may stop it
  logic alt_mode;

  assign alt_mode = ifc_reg[`UOIR_IFC_UART] | ifc_reg[`UOIR_IFC_SER3] |
                    ifc_reg[`UOIR_IFC_SER6];

  always_ff @(posedge clk)
  begin
    if (rst)
      serial_clk_on <= 1'b1;
    else
      serial_clk_on <= !(alt_mode && low_power_n &&
                         !ifc_reg[`UOIR_IFC_CLKKEEP]);
  end

endmodule
`default_nettype wire

// [rtl/uoir_defines.svh]
// constants for the transceiver interface, otg and rising-event bank
// assumes a 6-bit immediate register address and a 100 MHz clock
`ifndef UOIR_DEFINES_SVH
`define UOIR_DEFINES_SVH

// register addresses
`define UOIR_A_IFC        6'h07
`define UOIR_A_IFC_SET    6'h08
`define UOIR_A_IFC_CLR    6'h09
`define UOIR_A_OTG        6'h0a
`define UOIR_A_OTG_SET    6'h0b
`define UOIR_A_OTG_CLR    6'h0c
`define UOIR_A_RISE       6'h0d
`define UOIR_A_RISE_SET   6'h0e

// reset values and writable masks
`define UOIR_IFC_RST      8'h10
`define UOIR_OTG_RST      8'h06
`define UOIR_RISE_RST     8'h1f
`define UOIR_IFC_WMASK    8'hff
`define UOIR_IFC_AMASK    8'hfe
`define UOIR_OTG_WMASK    8'hff
`define UOIR_RISE_WMASK   8'h1f

// interface control bits
`define UOIR_IFC_PROT_DIS 7
`define UOIR_IFC_UNQUAL   6
`define UOIR_IFC_INVERT   5
`define UOIR_IFC_AUTOWAKE 4
`define UOIR_IFC_CLKKEEP  3
`define UOIR_IFC_UART     2
`define UOIR_IFC_SER3     1
`define UOIR_IFC_SER6     0

// otg control bits
`define UOIR_OTG_EXTSRC   7
`define UOIR_OTG_EXTSUP   6
`define UOIR_OTG_DRIVE    5
`define UOIR_OTG_CHARGE   4
`define UOIR_OTG_DISCH    3
`define UOIR_OTG_DM_PD    2
`define UOIR_OTG_DP_PD    1
`define UOIR_OTG_ID_PU    0

// rising-event enable bits
`define UOIR_EV_ID        4
`define UOIR_EV_SEND      3
`define UOIR_EV_SOK       2
`define UOIR_EV_VBUS      1
`define UOIR_EV_HDISC     0

// timing
`define UOIR_CLK_NS       10
`define UOIR_ID_SETTLE_NS 50000000
`define UOIR_ID_SETTLE_CYC (`UOIR_ID_SETTLE_NS / `UOIR_CLK_NS)

`endif

// [rtl/uoir_pkg.sv]
// types shared by the register bank and its bench
// assumes nothing beyond the defines header
`default_nettype none
package uoir_pkg;
  typedef logic [7:0] uoir_byte_t;
  typedef logic [5:0] uoir_addr_t;
  typedef enum logic [1:0] {UOIR_OP_BASE, UOIR_OP_SET, UOIR_OP_CLR,
                            UOIR_OP_NONE} uoir_op_e;
endpackage
`default_nettype wire

// [verif/uoir_regs_sva.sv]
// checker for the interface, otg and rising-event register bank
// assumes it is bound into uoir_regs and sees only that module's ports
`default_nettype none
module uoir_regs_sva
#(
  parameter int ID_SETTLE_CYCLES = 20
)
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       uart_exit,
  input wire logic       serial_exit,
  input wire logic       protect_en,
  input wire logic       uart_mode_sel,
  input wire logic       serial3_mode_sel,
  input wire logic       serial6_mode_sel,
  input wire logic       pump_enable_out,
  input wire logic       dminus_pd_en,
  input wire logic       dplus_pd_en,
  input wire logic       id_pu_en,
  input wire logic [4:0] rise_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int pu_cnt;

  // cycles with the id pullup on; saturates so it never wraps
  always_ff @(posedge clk)
  begin
    if (rst || !id_pu_en)
      pu_cnt <= 0;
    else if (pu_cnt < ID_SETTLE_CYCLES)
      pu_cnt <= pu_cnt + 1;
  end

  sequence s_pump_on;
    reg_wr && reg_addr == 6'h0b && reg_wdata[6:5] == 2'h3;
  endsequence
  sequence s_hole_rd;
    reg_rd && reg_addr == 6'h0f;
  endsequence

  AST_PROT: assert property ($changed(protect_en) |-> $past(reg_wr))
    else $error("protect changed without a write");
  AST_UART_EXIT: assert property (
    uart_exit && !reg_wr |=> !uart_mode_sel)
    else $error("uart mode kept after exit");
  AST_SER_EXIT: assert property (
    serial_exit && !reg_wr |=> !serial3_mode_sel && !serial6_mode_sel)
    else $error("serial mode kept after exit");
  AST_PUMP: assert property (s_pump_on |=> pump_enable_out)
    else $error("pump not on after supply and drive set");
  AST_SET: assert property (
    reg_wr && reg_addr == 6'h0b && reg_wdata[0] |=> id_pu_en)
    else $error("set alias did not set pullup bit");
  AST_CLR: assert property (
    reg_wr && reg_addr == 6'h0c && reg_wdata[1] |=> !dplus_pd_en)
    else $error("clear alias did not clear pulldown bit");
  AST_HOST: assert property (rise_event[0] |->
    (dminus_pd_en && dplus_pd_en) ||
    ($past(dminus_pd_en) && $past(dplus_pd_en)))
    else $error("disconnect event outside host mode");
  AST_ID: assert property (
    rise_event[4] |-> id_pu_en && pu_cnt >= ID_SETTLE_CYCLES - 2)
    else $error("id event while masked");
  AST_HOLE: assert property (
    s_hole_rd |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind uoir_regs uoir_regs_sva #(.ID_SETTLE_CYCLES(ID_SETTLE_CYCLES)) u_sva (.*);
`default_nettype wire

// [verif/uoir_link_model.sv]
// link-side model issuing register writes and reads on clk
// assumes the bank takes a strobe on one edge and answers the next
`default_nettype none
module uoir_link_model
(
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus before the first request
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h3f;
    reg_wdata = 8'h00;
  end

  // released lines carry the inverse so stale values cannot pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// [verif/uoir_regs_bench.sv]
// self-checking bench for the interface, otg and rising-event bank
// assumes the link model drives the bus and the bench the levels
`default_nettype none
module uoir_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uoir_pkg::*;
  localparam int SETTLE = 20;
  logic       clk = 1'b0, rst = 1'b1, low_power_n = 1'b1;
  logic       uart_exit = 1'b0, serial_exit = 1'b0, host_disc = 1'b0;
  logic       ext_vbus_ind_in = 1'b0, int_vbus_cmp = 1'b0;
  logic       id_grounded = 1'b0, session_end = 1'b0, session_ok = 1'b0;
  uoir_addr_t reg_addr;
  uoir_byte_t reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reg_rvalid, rise_any, protect_en;
  logic       rx_vbus_valid, auto_wake_signal, serial_clk_on;
  logic       uart_mode_sel, serial3_mode_sel, serial6_mode_sel;
  logic       pump_enable_out, vbus_drive, vbus_charge, vbus_discharge;
  logic       dminus_pd_en, dplus_pd_en, id_pu_en;
  logic [4:0] rise_event;
  int         mismatches = 0, n_tests = 0, cyc = 0;

  uoir_regs #(.ID_SETTLE_CYCLES(SETTLE)) DUT (.*);
  uoir_link_model lnk (.*);

  always #5 clk = ~clk;

  // cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input uoir_byte_t seen, input uoir_byte_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input uoir_addr_t a, input uoir_byte_t exp);
    uoir_byte_t d;
    lnk.rd(a, d);
    chk(d, exp);
  endtask

  // long enough for the three-flop level synchronisers
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic ev(input int i, input logic exp);
    logic got;
    got = 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      #1 got |= rise_event[i];
      chk(rise_any, |rise_event);
    end
    chk(got, exp);
  endtask

  task automatic t_reset();
    rdchk(6'h07, 8'h10);
    rdchk(6'h0a, 8'h06);
    rdchk(6'h0d, 8'h1f);
    rdchk(6'h0f, 8'h00);
    chk(protect_en, 1'b1);
    chk(auto_wake_signal, 1'b1);
  endtask

  task automatic t_ifc();
    lnk.wr(6'h07, 8'h80);
    chk(protect_en, 1'b0);
    rdchk(6'h08, 8'h80);
    lnk.wr(6'h08, 8'h07);
    rdchk(6'h07, 8'h86);
    lnk.wr(6'h07, 8'h07);
    chk({uart_mode_sel, serial3_mode_sel, serial6_mode_sel}, 8'h07);
    lnk.wr(6'h09, 8'h01);
    rdchk(6'h09, 8'h07);
    chk(uart_mode_sel, 1'b1);
    @(posedge clk) serial_exit <= 1'b1;
    @(posedge clk) serial_exit <= 1'b0;
    rdchk(6'h07, 8'h04);
    @(posedge clk) uart_exit <= 1'b1;
    @(posedge clk) uart_exit <= 1'b0;
    rdchk(6'h07, 8'h00);
    lnk.wr(6'h07, 8'h02);
    settle();
    chk(serial_clk_on, 1'b0);
    @(posedge clk) low_power_n <= 1'b0;
    settle();
    chk(serial_clk_on, 1'b1);
    @(posedge clk) low_power_n <= 1'b1;
    lnk.wr(6'h07, 8'h20);
    chk(auto_wake_signal, 1'b0);
  endtask

  task automatic t_otg();
    lnk.wr(6'h0b, 8'h60);
    chk(pump_enable_out, 1'b1);
    rdchk(6'h0a, 8'h66);
    lnk.wr(6'h0c, 8'h40);
    chk({pump_enable_out, vbus_drive}, 8'h01);
    lnk.wr(6'h0c, 8'h26);
    rdchk(6'h0a, 8'h00);
    chk(dminus_pd_en, 1'b0);
    @(posedge clk) int_vbus_cmp <= 1'b1;
    settle();
    chk(rx_vbus_valid, 1'b1);
    lnk.wr(6'h0b, 8'h80);
    @(posedge clk) int_vbus_cmp <= 1'b0;
    settle();
    chk(rx_vbus_valid, 1'b0);
    lnk.wr(6'h08, 8'h40);
    settle();
    chk(rx_vbus_valid, 1'b1);
    @(posedge clk) ext_vbus_ind_in <= 1'b1;
    settle();
    chk(rx_vbus_valid, 1'b0);
    lnk.wr(6'h0a, 8'h06);
  endtask

  task automatic t_ev();
    lnk.wr(6'h0b, 8'h08);
    chk(vbus_discharge, 1'b1);
    @(posedge clk) session_end <= 1'b1;
    ev(3, 1'b1);
    lnk.wr(6'h0c, 8'h08);
    lnk.wr(6'h0b, 8'h10);
    chk({vbus_charge, vbus_discharge}, 8'h02);
    lnk.wr(6'h0d, 8'he7);
    rdchk(6'h0d, 8'h07);
    @(posedge clk) session_end <= 1'b0;
    settle();
    @(posedge clk) session_end <= 1'b1;
    ev(3, 1'b0);
    lnk.wr(6'h0e, 8'h18);
    rdchk(6'h0d, 8'h1f);
    @(posedge clk) session_ok <= 1'b1;
    ev(2, 1'b1);
    @(posedge clk) int_vbus_cmp <= 1'b1;
    ev(1, 1'b1);
    @(posedge clk) host_disc <= 1'b1;
    ev(0, 1'b1);
    @(posedge clk) host_disc <= 1'b0;
    settle();
    lnk.wr(6'h0c, 8'h02);
    @(posedge clk) host_disc <= 1'b1;
    ev(0, 1'b0);
    @(posedge clk) id_grounded <= 1'b1;
    ev(4, 1'b0);
    lnk.wr(6'h0b, 8'h01);
    chk(id_pu_en, 1'b1);
    ev(4, 1'b0);
    ev(4, 1'b0);
    ev(4, 1'b0);
    @(posedge clk) id_grounded <= 1'b0;
    settle();
    @(posedge clk) id_grounded <= 1'b1;
    ev(4, 1'b1);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ifc();
    t_otg();
    t_ev();
    wrap_up();
  end
endmodule
`default_nettype wire
